/* logic/ocs_pkg.sv */
// Constants shared by the cable and supply status block
package ocs_pkg;
  localparam int          ADDR_W         = 5;
  localparam int          REG_W          = 8;
  // Register byte offsets
  localparam logic [4:0]  OFS_FUNC_CTRL  = 5'h00;
  localparam logic [4:0]  OFS_IFACE_CTRL = 5'h04;
  localparam logic [4:0]  OFS_OTG_CTRL   = 5'h08;
  localparam logic [4:0]  OFS_IEN_RISE   = 5'h0c;
  localparam logic [4:0]  OFS_IEN_FALL   = 5'h10;
  localparam logic [4:0]  OFS_INT_STATUS = 5'h14;
  localparam logic [4:0]  OFS_INT_LATCH  = 5'h18;
  localparam logic [4:0]  OFS_DEV_STATUS = 5'h1c;
  // Reset values
  localparam logic [7:0]  RST_FUNC_CTRL  = 8'h41;
  localparam logic [7:0]  RST_IFACE_CTRL = 8'h00;
  localparam logic [7:0]  RST_OTG_CTRL   = 8'h06;
  localparam logic [7:0]  RST_IEN        = 8'h1f;
  // Field positions
  localparam int          FC_RESET       = 5;
  localparam int          IC_AUTO_RESUME = 4;
  localparam int          OC_PLUG_PULLUP = 0;
  localparam int          OC_DP_PULLDOWN = 1;
  localparam int          OC_DM_PULLDOWN = 2;
  localparam int          OC_DISCHARGE   = 3;
  localparam int          OC_CHARGE      = 4;
  localparam int          OC_DRIVE       = 5;
  localparam int          OC_DRIVE_EXT   = 6;
  localparam int          IS_SUPPLY_VLD  = 1;
  localparam int          IS_SESS_VLD    = 2;
  localparam int          IS_SESS_END    = 3;
  localparam int          IS_PLUG        = 4;
  localparam int          DS_PLL_LOCK    = 0;
  localparam int          DS_OPERATING   = 1;
  localparam int          DS_CORE_RESET  = 2;
  // Comparator input order
  localparam int          CMP_N          = 4;
  localparam int          CI_SUPPLY      = 0;
  localparam int          CI_SESS_VLD    = 1;
  localparam int          CI_SESS_END    = 2;
  localparam int          CI_PLUG        = 3;
  // AXI responses
  localparam logic [1:0]  RESP_OKAY      = 2'b00;
  localparam logic [1:0]  RESP_SLVERR    = 2'b10;
  typedef enum logic [1:0] {
    OCS_POR     = 2'b00,
    OCS_RUN     = 2'b01,
    OCS_CORE_RST = 2'b10
  } ocs_state_e;
endpackage : ocs_pkg

/* logic/ocs_status.sv */
// Cable plug and bus supply status block with AXI4-Lite registers
// Notes on behaviour
// - Link clock output runs only after PLL lock
// - Host auto-resume bit resets to zero
// - Power-on pulse loads defaults, then normal operation
// - Only power-on reset restores register defaults
// - Reset pin acts like function reset bit
// - Plug flag: 0 grounded A, 1 floating B
// - Pullup bit gates strong pull-up; weak stays
// - Plug flag readable at status bit 4
// - Host mode: plug flag change raises event
// - Session-end flag rises below 0.5 V
// - Session-end off when both enables clear
// - Session-valid enables mask events only
// - Supply-valid off and bit 1 zero
// - One shared session-valid flag both roles
// - Supply-valid means supply above 4.4 V
// - Charge pump enable is OR bits 5,6
// - OTG bit 3 discharge, bit 4 charge
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ocs_status
  import ocs_pkg::*;
#(
  parameter int POR_CYCLES   = 16,
  parameter int RESET_CYCLES = 8,
  parameter int FILT_LEN     = 3
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              pll_locked,
  input  wire logic              reset_pin,
  input  wire logic              supply_valid_cmp,
  input  wire logic              session_valid_cmp,
  input  wire logic              session_end_cmp,
  input  wire logic              plug_line_high,
  output logic                   link_clock_output,
  output logic                   supply_valid_cmp_en,
  output logic                   session_end_cmp_en,
  output logic                   plug_detect_pullup_en,
  output logic                   supply_discharge_en,
  output logic                   supply_charge_en,
  output logic                   charge_pump_enable,
  output logic                   host_resume_auto_bit,
  output logic                   core_reset,
  output logic                   event_pending
);
  if (FILT_LEN < 2 || POR_CYCLES < 1 || RESET_CYCLES < 1 || POR_CYCLES > 255 ||
      RESET_CYCLES > 255) begin : g_bad_params
    $error("ocs_status: unsupported parameter value");
  end

  localparam logic [7:0] POR_LAST = 8'(POR_CYCLES - 1);
  localparam logic [7:0] RST_LAST = 8'(RESET_CYCLES - 1);

  // Async inputs: two flops, then the comparators a run-length filter
  logic [CMP_N-1:0] cmp_raw;
  logic [CMP_N-1:0] cmp_filt_reg;
  logic [1:0]       lock_sync_reg;
  logic [1:0]       pin_sync_reg;
  assign cmp_raw = {plug_line_high, session_end_cmp, session_valid_cmp, supply_valid_cmp};

  genvar gi;
  generate
    for (gi = 0; gi < CMP_N; gi++) begin : g_cmp
      logic [1:0]          sync_reg;
      logic [FILT_LEN-1:0] hist_reg;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync_reg          <= 2'b00;
          hist_reg          <= '0;
          cmp_filt_reg[gi]  <= 1'b0;
        end else begin
          sync_reg <= {sync_reg[0], cmp_raw[gi]};
          hist_reg <= {hist_reg[FILT_LEN-2:0], sync_reg[1]};
          // A level must hold for the whole window, so one glitch never lands
          if (&hist_reg || ~|hist_reg) begin
            cmp_filt_reg[gi] <= hist_reg[0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_sync_reg <= 2'b00;
      pin_sync_reg  <= 2'b00;
    end else begin
      lock_sync_reg <= {lock_sync_reg[0], pll_locked};
      pin_sync_reg  <= {pin_sync_reg[0], reset_pin};
    end
  end

  ocs_state_e  state_reg, state_next;
  logic [7:0]  cnt_reg, cnt_next;
  logic [7:0]  func_reg, func_next;
  logic [7:0]  iface_reg, iface_next;
  logic [7:0]  otg_reg, otg_next;
  logic [7:0]  ien_rise_reg, ien_rise_next;
  logic [7:0]  ien_fall_reg, ien_fall_next;
  logic [7:0]  latch_reg, latch_next;
  logic [7:0]  prev_reg, prev_next;
  logic        clk_out_reg, clk_out_next;
  logic        awready_reg, awready_next;
  logic        bvalid_reg, bvalid_next;
  logic [1:0]  bresp_reg, bresp_next;
  logic        arready_reg, arready_next;
  logic        rvalid_reg, rvalid_next;
  logic [1:0]  rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0]  status_live;
  logic [7:0]  rise_ev;
  logic [7:0]  fall_ev;
  logic        host_mode;
  logic        do_write;
  logic        do_read;
  logic        running;

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= OFS_DEV_STATUS);
  endfunction : mapped

  // Live status: disabled comparators read as zero
  always_comb begin
    status_live                = 8'h00;
    status_live[IS_SUPPLY_VLD] = cmp_filt_reg[CI_SUPPLY] &
                                 (ien_rise_reg[IS_SUPPLY_VLD] | ien_fall_reg[IS_SUPPLY_VLD]);
    status_live[IS_SESS_VLD]   = cmp_filt_reg[CI_SESS_VLD];
    status_live[IS_SESS_END]   = cmp_filt_reg[CI_SESS_END] &
                                 (ien_rise_reg[IS_SESS_END] | ien_fall_reg[IS_SESS_END]);
    status_live[IS_PLUG]       = cmp_filt_reg[CI_PLUG];
  end

  assign host_mode = otg_reg[OC_DP_PULLDOWN] & otg_reg[OC_DM_PULLDOWN];
  assign running   = (state_reg != OCS_POR);
  assign do_write  = awready_reg;
  assign do_read   = arready_reg;

  always_comb begin
    rise_ev          = status_live & ~prev_reg & ien_rise_reg;
    fall_ev          = ~status_live & prev_reg & ien_fall_reg;
    rise_ev[IS_PLUG] = rise_ev[IS_PLUG] & host_mode;
    fall_ev[IS_PLUG] = fall_ev[IS_PLUG] & host_mode;
  end

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    func_next     = func_reg;
    iface_next    = iface_reg;
    otg_next      = otg_reg;
    ien_rise_next = ien_rise_reg;
    ien_fall_next = ien_fall_reg;
    latch_next    = latch_reg;
    prev_next     = status_live;
    clk_out_next  = lock_sync_reg[1] ? ~clk_out_reg : 1'b0;
    awready_next  = 1'b0;
    bvalid_next   = bvalid_reg & ~s_axi_bready;
    bresp_next    = bresp_reg;
    arready_next  = 1'b0;
    rvalid_next   = rvalid_reg & ~s_axi_rready;
    rresp_next    = rresp_reg;
    rdata_next    = rdata_reg;
    unique case (state_reg)
      OCS_POR: begin
        // Edge history follows the lines here, so settled levels raise no event at exit
        cnt_next  = cnt_reg + 8'h01;
        if (cnt_reg == POR_LAST) begin
          state_next = OCS_RUN;
          cnt_next   = 8'h00;
        end
      end
      OCS_RUN: begin
        if (func_reg[FC_RESET] || pin_sync_reg[1]) begin
          state_next = OCS_CORE_RST;
          cnt_next   = 8'h00;
        end
      end
      OCS_CORE_RST: begin
        // Core reset leaves the register set untouched except the function reset bit, cleared at exit
        cnt_next = cnt_reg + 8'h01;
        if (cnt_reg >= RST_LAST && !pin_sync_reg[1]) begin
          state_next           = OCS_RUN;
          func_next[FC_RESET]  = 1'b0;
        end
      end
      default: state_next = OCS_POR;
    endcase
    // Write: address and data taken together in one beat
    if (running && s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg) begin
      awready_next = 1'b1;
    end
    if (do_write) begin
      bvalid_next = 1'b1;
      bresp_next  = mapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_wstrb[0]) begin
        unique case (s_axi_awaddr)
          OFS_FUNC_CTRL:  func_next     = s_axi_wdata[7:0];
          OFS_IFACE_CTRL: iface_next    = s_axi_wdata[7:0];
          OFS_OTG_CTRL:   otg_next      = s_axi_wdata[7:0];
          OFS_IEN_RISE:   ien_rise_next = s_axi_wdata[7:0];
          OFS_IEN_FALL:   ien_fall_next = s_axi_wdata[7:0];
          OFS_INT_LATCH:  latch_next    = latch_reg & ~s_axi_wdata[7:0];
          default:        ;
        endcase
      end
    end
    // A new edge wins over a clear in the same cycle
    if (running) begin
      latch_next = latch_next | rise_ev | fall_ev;
    end
    if (running && s_axi_arvalid && !arready_reg && !rvalid_reg) begin
      arready_next = 1'b1;
    end
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      rdata_next  = 32'h0000_0000;
      unique case (s_axi_araddr)
        OFS_FUNC_CTRL:  rdata_next[7:0] = func_reg;
        OFS_IFACE_CTRL: rdata_next[7:0] = iface_reg;
        OFS_OTG_CTRL:   rdata_next[7:0] = otg_reg;
        OFS_IEN_RISE:   rdata_next[7:0] = ien_rise_reg;
        OFS_IEN_FALL:   rdata_next[7:0] = ien_fall_reg;
        OFS_INT_STATUS: rdata_next[7:0] = status_live;
        OFS_INT_LATCH:  rdata_next[7:0] = latch_reg;
        OFS_DEV_STATUS: begin
          rdata_next[DS_PLL_LOCK]   = lock_sync_reg[1];
          rdata_next[DS_OPERATING]  = running;
          rdata_next[DS_CORE_RESET] = (state_reg == OCS_CORE_RST);
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // Only the supply-cycle reset reaches the register set
      state_reg    <= OCS_POR;
      cnt_reg      <= 8'h00;
      func_reg     <= RST_FUNC_CTRL;
      iface_reg    <= RST_IFACE_CTRL;
      otg_reg      <= RST_OTG_CTRL;
      ien_rise_reg <= RST_IEN;
      ien_fall_reg <= RST_IEN;
      latch_reg    <= 8'h00;
      prev_reg     <= 8'h00;
      clk_out_reg  <= 1'b0;
      awready_reg  <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= RESP_OKAY;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rresp_reg    <= RESP_OKAY;
      rdata_reg    <= 32'h0000_0000;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      func_reg     <= func_next;
      iface_reg    <= iface_next;
      otg_reg      <= otg_next;
      ien_rise_reg <= ien_rise_next;
      ien_fall_reg <= ien_fall_next;
      latch_reg    <= latch_next;
      prev_reg     <= prev_next;
      clk_out_reg  <= clk_out_next;
      awready_reg  <= awready_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      arready_reg  <= arready_next;
      rvalid_reg   <= rvalid_next;
      rresp_reg    <= rresp_next;
      rdata_reg    <= rdata_next;
    end
  end

  // Pin-side outputs, registered so each leaves from a flop
  logic [8:0] pins_reg, pins_next;
  always_comb begin
    pins_next    = 9'h000;
    pins_next[0] = ien_rise_reg[IS_SUPPLY_VLD] | ien_fall_reg[IS_SUPPLY_VLD];
    pins_next[1] = ien_rise_reg[IS_SESS_END] | ien_fall_reg[IS_SESS_END];
    // Weak pull-up is analog and always on; this gates the strong one only
    pins_next[2] = otg_reg[OC_PLUG_PULLUP];
    pins_next[3] = otg_reg[OC_DISCHARGE];
    pins_next[4] = otg_reg[OC_CHARGE];
    pins_next[5] = otg_reg[OC_DRIVE] | otg_reg[OC_DRIVE_EXT];
    pins_next[6] = iface_reg[IC_AUTO_RESUME];
    pins_next[7] = (state_reg != OCS_RUN);
    pins_next[8] = |latch_reg;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_reg <= 9'h080;
    end else begin
      pins_reg <= pins_next;
    end
  end

  assign supply_valid_cmp_en   = pins_reg[0];
  assign session_end_cmp_en    = pins_reg[1];
  assign plug_detect_pullup_en = pins_reg[2];
  assign supply_discharge_en   = pins_reg[3];
  assign supply_charge_en      = pins_reg[4];
  assign charge_pump_enable    = pins_reg[5];
  assign host_resume_auto_bit  = pins_reg[6];
  assign core_reset            = pins_reg[7];
  assign event_pending         = pins_reg[8];
  assign link_clock_output     = clk_out_reg;
  assign s_axi_awready         = awready_reg;
  assign s_axi_wready          = awready_reg;
  assign s_axi_bvalid          = bvalid_reg;
  assign s_axi_bresp           = bresp_reg;
  assign s_axi_arready         = arready_reg;
  assign s_axi_rvalid          = rvalid_reg;
  assign s_axi_rresp           = rresp_reg;
  assign s_axi_rdata           = rdata_reg;
endmodule : ocs_status
`default_nettype wire

/* test/ocs_status_props.sv */
// Port checker for the cable and supply status block
`timescale 1ns/10ps
`default_nettype none
module ocs_status_props
  import ocs_pkg::*;
#(
  parameter int POR_CYCLES   = 16,
  parameter int RESET_CYCLES = 8,
  parameter int FILT_LEN     = 3
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       s_axi_rready,
  input wire logic       pll_locked,
  input wire logic       reset_pin,
  input wire logic       link_clock_output,
  input wire logic       core_reset
);
  logic [3:0] up_reg;
  logic [3:0] up_next;

  // Cycles since reset release, saturating; keeps the sync chains out of the clock check
  always_comb begin
    up_next = (up_reg == 4'hf) ? up_reg : up_reg + 4'h1;
    if (!aresetn) up_next = 4'h0;
  end
  always_ff @(posedge aclk) begin
    up_reg <= up_next;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence lock_held; pll_locked [*5]; endsequence
  sequence lock_lost; (!pll_locked) [*5]; endsequence
  sequence por_start; $rose(aresetn); endsequence
  sequence lock_settled; lock_held ##0 up_reg == 4'hf; endsequence

  clk_off_a: assert property (lock_lost |-> !link_clock_output)
    else $error("link clock runs without lock");
  clk_on_a: assert property (lock_settled |-> $changed(link_clock_output))
    else $error("link clock stalled under lock");
  por_hold_a: assert property (por_start |-> core_reset [*8])
    else $error("power-on pulse too short");
  por_quiet_a: assert property (por_start |-> (!s_axi_awready && !s_axi_arready) [*8])
    else $error("bus served during power-on");
  pin_reset_a: assert property (reset_pin |-> ##[1:6] core_reset)
    else $error("reset pin ignored");
  core_hold_a: assert property ($rose(core_reset) && up_reg == 4'hf |-> core_reset [*8])
    else $error("core reset too short");
  aw_resp_a: assert property (s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write answer late");
  ar_resp_a: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer stuck");
endmodule : ocs_status_props
`default_nettype wire

/* test/ocs_link_model.sv */
// Link controller model: register master on AXI4-Lite
`timescale 1ns/10ps
`default_nettype none
module ocs_link_model (
  input  wire logic        aclk,
  output var  logic [4:0]  awaddr,
  output var  logic        awvalid,
  input  wire logic        awready,
  output var  logic [31:0] wdata,
  output var  logic [3:0]  wstrb,
  output var  logic        wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output var  logic        bready,
  output var  logic [4:0]  araddr,
  output var  logic        arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output var  logic        rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end

  // Defaults are restored by writing them back or by aresetn, never by a core reset
  task automatic wr(input logic [4:0] a, input logic [31:0] d,
                    output logic [1:0] r, output bit to);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (!(awready && wready) && n < 300);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (!bvalid && n < 300);
    r = bresp;
    to = !bvalid;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d,
                    output logic [1:0] r, output bit to);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin @(posedge aclk); n++; end while (!arready && n < 300);
    arvalid <= 1'b0;
    do begin @(posedge aclk); n++; end while (!rvalid && n < 300);
    d = rdata;
    r = rresp;
    to = !rvalid;
    rready <= 1'b0;
  endtask : rd
endmodule : ocs_link_model
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the cable and supply status block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h exp %h", $time, (a), (e)); end end
module testbench;
  import ocs_pkg::*;
  logic        aclk, aresetn, pll_locked, reset_pin, sv_cmp, ss_cmp, se_cmp, plug_hi;
  logic [4:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        link_clock_output, sv_en, se_en, plug_detect_pullup_en, supply_discharge_en;
  logic        supply_charge_en, charge_pump_enable, host_resume_auto_bit, core_reset;
  logic        event_pending;
  int          errors, total_checks;
  logic [3:0]  otg_pins;
  assign otg_pins = {charge_pump_enable, supply_charge_en, supply_discharge_en,
                     plug_detect_pullup_en};

  ocs_status #(.POR_CYCLES(16), .RESET_CYCLES(8), .FILT_LEN(3)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pll_locked(pll_locked), .reset_pin(reset_pin), .supply_valid_cmp(sv_cmp),
    .session_valid_cmp(ss_cmp), .session_end_cmp(se_cmp), .plug_line_high(plug_hi),
    .link_clock_output(link_clock_output), .supply_valid_cmp_en(sv_en),
    .session_end_cmp_en(se_en), .plug_detect_pullup_en(plug_detect_pullup_en),
    .supply_discharge_en(supply_discharge_en), .supply_charge_en(supply_charge_en),
    .charge_pump_enable(charge_pump_enable), .host_resume_auto_bit(host_resume_auto_bit),
    .core_reset(core_reset), .event_pending(event_pending));

  ocs_link_model u_link (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  task automatic complete_run;
    if (errors == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [1:0] r;
    bit         to;
    u_link.wr(a, {24'h0, d}, r, to);
    if (to) begin errors++; complete_run(); end
    // Aligned offsets up to the last register answer OKAY, anything else SLVERR
    `CHK(r, (a[1:0] == 2'b00 && a <= OFS_DEV_STATUS) ? RESP_OKAY : RESP_SLVERR)
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    bit to;
    u_link.rd(a, d, r, to);
    if (to) begin errors++; complete_run(); end
  endtask : rd

  task automatic chk_reg(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK({r, d}, {RESP_OKAY, 24'h0, e})
  endtask : chk_reg

  // Comparator path is sync plus filter, well inside ten cycles
  task automatic settle;
    repeat (10) @(posedge aclk);
  endtask : settle

  task automatic wait_run;
    int n;
    n = 0;
    while (core_reset !== 1'b0 && n < 100) begin @(posedge aclk); n++; end
    if (n == 100) begin errors++; complete_run(); end
  endtask : wait_run

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    complete_run();
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    {aresetn, pll_locked, reset_pin, sv_cmp, ss_cmp} = '0;
    {se_cmp, plug_hi} = 2'b11;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    `CHK(link_clock_output, 1'b0)
    pll_locked <= 1'b1;
    chk_reg(OFS_FUNC_CTRL, RST_FUNC_CTRL);
    chk_reg(OFS_IFACE_CTRL, 8'h00);
    chk_reg(OFS_OTG_CTRL, RST_OTG_CTRL);
    chk_reg(OFS_IEN_FALL, RST_IEN);
    chk_reg(OFS_INT_LATCH, 8'h00);
    `CHK(event_pending, 1'b0)
    for (int i = 3; i <= 6; i++) begin
      wr(OFS_OTG_CTRL, 8'h01 << i);
      settle();
      `CHK(otg_pins, {i >= 5, i == 4, i == 3, 1'b0})
    end
    wr(OFS_OTG_CTRL, 8'h01);
    wr(OFS_IFACE_CTRL, 8'h10);
    settle();
    `CHK({host_resume_auto_bit, plug_detect_pullup_en}, 2'b11)
    chk_reg(OFS_INT_STATUS, 8'h18);
    wr(OFS_INT_LATCH, 8'h1f);
    sv_cmp <= 1'b1;
    @(posedge aclk);
    sv_cmp <= 1'b0;
    settle();
    chk_reg(OFS_INT_LATCH, 8'h00);
    wr(OFS_IEN_RISE, 8'h11);
    wr(OFS_IEN_FALL, 8'h11);
    {sv_cmp, ss_cmp} <= 2'b11;
    settle();
    chk_reg(OFS_INT_STATUS, 8'h14);
    `CHK({sv_en, se_en}, 2'b00)
    chk_reg(OFS_INT_LATCH, 8'h00);
    wr(OFS_IEN_RISE, 8'h1f);
    settle();
    chk_reg(OFS_INT_STATUS, 8'h1e);
    `CHK({sv_en, se_en}, 2'b11)
    wr(OFS_OTG_CTRL, 8'h07);
    wr(OFS_INT_LATCH, 8'h1f);
    plug_hi <= 1'b0;
    settle();
    chk_reg(OFS_INT_STATUS, 8'h0e);
    chk_reg(OFS_INT_LATCH, 8'h10);
    `CHK(event_pending, 1'b1)
    wr(OFS_INT_LATCH, 8'h1f);
    wr(OFS_OTG_CTRL, 8'h01);
    plug_hi <= 1'b1;
    settle();
    chk_reg(OFS_INT_LATCH, 8'h00);
    wr(OFS_OTG_CTRL, RST_OTG_CTRL);
    chk_reg(OFS_OTG_CTRL, RST_OTG_CTRL);
    reset_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK(core_reset, 1'b1)
    reset_pin <= 1'b0;
    wait_run();
    chk_reg(OFS_IFACE_CTRL, 8'h10);
    wr(OFS_FUNC_CTRL, RST_FUNC_CTRL | 8'h20);
    repeat (3) @(posedge aclk);
    `CHK(core_reset, 1'b1)
    wait_run();
    chk_reg(OFS_FUNC_CTRL, RST_FUNC_CTRL);
    chk_reg(OFS_IFACE_CTRL, 8'h10);
    wr(5'h1e, 8'hff);
    rd(5'h1e, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_reg(OFS_IFACE_CTRL, 8'h00);
    `CHK({host_resume_auto_bit, charge_pump_enable}, 2'b00)
    pll_locked <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK(link_clock_output, 1'b0)
    complete_run();
  end
endmodule : testbench

bind ocs_status ocs_status_props #(
  .POR_CYCLES(POR_CYCLES), .RESET_CYCLES(RESET_CYCLES), .FILT_LEN(FILT_LEN)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pll_locked(pll_locked), .reset_pin(reset_pin),
  .link_clock_output(link_clock_output), .core_reset(core_reset));
`default_nettype wire
